// ### hw/interlock_cfg.svh
// Timing constants and rule notes for the torque-off enable interlock
// Notes on behaviour
// - Either input low holds torque off
// - Both inputs high permit normal operation
// - Feedback relay follows torque-off and fault
// - Controller treats wrong feedback as failure
// - Controller starts stopped, checks both feedbacks
// - Controller raises safety input before enable
// - Controller rechecks feedbacks, then issues start
// - Safety rising under enable locks restart
// - Tied inputs: enable not within 24 ms; the sequencer raises enable after only SEQ_GAP_CYC (64 cycles)
// - Second input over 4 s raises alarm
// - Drive-ready relay closed when enable accepted
// - Check inputs and feedback before pulses
// - Safety fault latches alarm until cleared
`ifndef INTERLOCK_CFG_SVH
`define INTERLOCK_CFG_SVH
`define CLK_HZ            25000000
`define FILT_CYC          4
`define MISSING_S         4
`define MISSING_CYC       (`MISSING_S * `CLK_HZ)
`define TIE_GAP_MS        24
`define TIE_GAP_CYC       ((`TIE_GAP_MS * `CLK_HZ) / 1000)
`define CNT_W             28
`define SEQ_GAP_CYC       64
`define FBK_SETTLE_CYC    4
`endif

// ### hw/interlock_pkg.sv
// Types shared by both ends of the interlock
package interlock_pkg;
  typedef enum logic [1:0] {
    DEV_OFF,
    DEV_READY,
    DEV_RUN,
    DEV_LOCK
  } dev_state_t;
  typedef enum logic [2:0] {
    CTL_IDLE,
    CTL_PRECHECK,
    CTL_SAFETY,
    CTL_ENABLE,
    CTL_POSTCHECK,
    CTL_RUN,
    CTL_STOP,
    CTL_FAIL
  } ctl_state_t;
endpackage

// ### hw/interlock_if.sv
// Wires between the lift controller and the interlock
`timescale 1ns/100ps
interface interlock_if;
  logic enable_in;
  logic safety_in;
  logic fbk_closed;
  logic ready_closed;
  logic start_cmd;
  logic stop_cmd;
  modport device (
    input  enable_in,
    input  safety_in,
    input  start_cmd,
    input  stop_cmd,
    output fbk_closed,
    output ready_closed
  );
  modport controller (
    output enable_in,
    output safety_in,
    output start_cmd,
    output stop_cmd,
    input  fbk_closed,
    input  ready_closed
  );
endinterface

// ### hw/torque_off_enable_interlock.sv
// Device end: torque-off decision, lockout, alarms and feedback relays
`timescale 1ns/100ps
`include "interlock_cfg.svh"
module torque_off_enable_interlock (
  input  wire logic        CLK,
  input  wire logic        RST,
  interlock_if.device      LINK,
  input  wire logic        ALARM_CLEAR,
  input  wire logic        FBK_SENSE,
  output logic             PULSE_EN,
  output logic             TORQUE_OFF,
  output logic             LOCKOUT,
  output logic             MISSING_ALARM,
  output logic             SAFETY_ALARM
);
  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] en_sync_r;
  logic [1:0] sf_sync_r;
  logic [1:0] fs_sync_r;
  logic [2:0] en_cnt_r;
  logic [2:0] sf_cnt_r;
  logic       en_f_r;
  logic       sf_f_r;
  logic       en_d_r;
  logic       sf_d_r;

  // Inputs cross from pins; a glitch on enable or safety shorter than the filter is dropped
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      en_sync_r <= 2'h0;
      sf_sync_r <= 2'h0;
      fs_sync_r <= 2'h3;
    end else begin
      en_sync_r <= {en_sync_r[0], LINK.enable_in};
      sf_sync_r <= {sf_sync_r[0], LINK.safety_in};
      fs_sync_r <= {fs_sync_r[0], FBK_SENSE};
    end
  end

  wire en_s = en_sync_r[1];
  wire sf_s = sf_sync_r[1];
  wire fbk_s = fs_sync_r[1];

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      en_cnt_r <= 3'h0;
      en_f_r   <= 1'b0;
    end else if (en_s == en_f_r) begin
      en_cnt_r <= 3'h0;
    end else if (en_cnt_r == 3'(`FILT_CYC - 1)) begin
      en_cnt_r <= 3'h0;
      en_f_r   <= en_s;
    end else begin
      en_cnt_r <= en_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sf_cnt_r <= 3'h0;
      sf_f_r   <= 1'b0;
    end else if (sf_s == sf_f_r) begin
      sf_cnt_r <= 3'h0;
    end else if (sf_cnt_r == 3'(`FILT_CYC - 1)) begin
      sf_cnt_r <= 3'h0;
      sf_f_r   <= sf_s;
    end else begin
      sf_cnt_r <= sf_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      en_d_r <= 1'b0;
      sf_d_r <= 1'b0;
    end else begin
      en_d_r <= en_f_r;
      sf_d_r <= sf_f_r;
    end
  end

  wire sf_rise = sf_f_r & ~sf_d_r;
  wire en_fall = ~en_f_r & en_d_r;
  wire both_on = en_f_r & sf_f_r;
  wire any_off = ~en_f_r | ~sf_f_r;

  ////////////////////////////////////////////////////////////////////////////
  // Missing second input: counts while exactly one input is high
  logic [`CNT_W-1:0] miss_cnt_r;
  logic              missing_r;
  wire               one_only = en_f_r ^ sf_f_r;
  wire               miss_hit = miss_cnt_r == `CNT_W'(`MISSING_CYC);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      miss_cnt_r <= '0;
    end else if (!one_only) begin
      miss_cnt_r <= '0;
    end else if (!miss_hit) begin
      miss_cnt_r <= miss_cnt_r + `CNT_W'(1);
    end
  end

  // Set wins over clear
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      missing_r <= 1'b0;
    end else if (one_only && miss_hit) begin
      missing_r <= 1'b1;
    end else if (ALARM_CLEAR) begin
      missing_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  interlock_pkg::dev_state_t state_r;
  interlock_pkg::dev_state_t state_nxt;
  logic                      safety_r;
  logic                      fbk_r;
  logic [2:0]                open_cnt_r;
  wire                       open_settled = open_cnt_r == 3'(`FBK_SETTLE_CYC);

  // Readback lags the relay drive; judge it only once that lag is over
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      open_cnt_r <= 3'h0;
    end else if (fbk_r) begin
      open_cnt_r <= 3'h0;
    end else if (!open_settled) begin
      open_cnt_r <= open_cnt_r + 3'h1;
    end
  end

  // Feedback relay must read open while power stage may run, closed otherwise
  wire fbk_bad   = fbk_s != (state_r != interlock_pkg::DEV_RUN);
  wire checks_ok = both_on && !fbk_bad && !safety_r && !missing_r;
  wire fault_ev  = (state_r == interlock_pkg::DEV_RUN) && fbk_s && open_settled;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      interlock_pkg::DEV_OFF: begin
        if (sf_rise && en_f_r) begin
          state_nxt = interlock_pkg::DEV_LOCK;
        end else if (both_on) begin
          state_nxt = interlock_pkg::DEV_READY;
        end
      end
      interlock_pkg::DEV_READY: begin
        if (any_off) begin
          state_nxt = interlock_pkg::DEV_OFF;
        end else if (LINK.start_cmd && checks_ok) begin
          state_nxt = interlock_pkg::DEV_RUN;
        end
      end
      interlock_pkg::DEV_RUN: begin
        if (any_off || safety_r || fault_ev) begin
          state_nxt = interlock_pkg::DEV_OFF;
        end else if (LINK.stop_cmd) begin
          state_nxt = interlock_pkg::DEV_READY;
        end
      end
      interlock_pkg::DEV_LOCK: begin
        if (en_fall) begin
          state_nxt = interlock_pkg::DEV_OFF;
        end
      end
      default: begin
        state_nxt = interlock_pkg::DEV_OFF;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_r <= interlock_pkg::DEV_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Latched until manual clear; a fault in the clear cycle still sets
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      safety_r <= 1'b0;
    end else if (fault_ev) begin
      safety_r <= 1'b1;
    end else if (ALARM_CLEAR) begin
      safety_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic pulse_r;
  logic ready_r;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pulse_r <= 1'b0;
      fbk_r   <= 1'b1;
      ready_r <= 1'b0;
    end else begin
      pulse_r <= state_nxt == interlock_pkg::DEV_RUN;
      fbk_r   <= state_nxt != interlock_pkg::DEV_RUN || safety_r;
      ready_r <= en_f_r && !safety_r && state_nxt != interlock_pkg::DEV_LOCK;
    end
  end

  assign PULSE_EN          = pulse_r;
  assign TORQUE_OFF        = ~pulse_r;
  assign LOCKOUT           = state_r == interlock_pkg::DEV_LOCK;
  assign MISSING_ALARM     = missing_r;
  assign SAFETY_ALARM      = safety_r;
  assign LINK.fbk_closed   = fbk_r;
  assign LINK.ready_closed = ready_r;
endmodule

// ### hw/lift_sequencer.sv
// Controller end: sequences the inputs and checks the feedback relays
`timescale 1ns/100ps
`include "interlock_cfg.svh"
module lift_sequencer (
  input  wire logic        CLK,
  input  wire logic        RST,
  interlock_if.controller  LINK,
  input  wire logic        RUN_REQ,
  output logic             RUNNING,
  output logic             FAILED
);
  ////////////////////////////////////////////////////////////////////////////
  logic [1:0]  fb_sync_r;
  logic [1:0]  rd_sync_r;
  logic [19:0] wait_r;
  interlock_pkg::ctl_state_t state_r;
  logic en_r;
  logic sf_r;
  logic start_r;
  logic stop_r;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      fb_sync_r <= 2'h3;
      rd_sync_r <= 2'h0;
    end else begin
      fb_sync_r <= {fb_sync_r[0], LINK.fbk_closed};
      rd_sync_r <= {rd_sync_r[0], LINK.ready_closed};
    end
  end

  wire fb   = fb_sync_r[1];
  wire rd   = rd_sync_r[1];
  // Inputs are never tied here; gap covers far-side sync and filter only
  wire gone = wait_r == 20'(`SEQ_GAP_CYC);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_r <= interlock_pkg::CTL_IDLE;
      en_r    <= 1'b0;
      sf_r    <= 1'b0;
      start_r <= 1'b0;
      stop_r  <= 1'b0;
      wait_r  <= 20'h0;
    end else begin
      start_r <= 1'b0;
      stop_r  <= 1'b0;
      wait_r  <= gone ? wait_r : wait_r + 20'h1;
      case (state_r)
        interlock_pkg::CTL_IDLE: begin
          if (RUN_REQ) begin
            state_r <= interlock_pkg::CTL_PRECHECK;
          end
        end
        interlock_pkg::CTL_PRECHECK: begin
          if (!fb || rd) begin
            state_r <= interlock_pkg::CTL_FAIL;
          end else begin
            sf_r    <= 1'b1;
            wait_r  <= 20'h0;
            state_r <= interlock_pkg::CTL_SAFETY;
          end
        end
        interlock_pkg::CTL_SAFETY: begin
          if (gone) begin
            en_r    <= 1'b1;
            wait_r  <= 20'h0;
            state_r <= interlock_pkg::CTL_ENABLE;
          end
        end
        interlock_pkg::CTL_ENABLE: begin
          if (gone) begin
            state_r <= interlock_pkg::CTL_POSTCHECK;
          end
        end
        interlock_pkg::CTL_POSTCHECK: begin
          if (!fb || !rd) begin
            state_r <= interlock_pkg::CTL_FAIL;
          end else begin
            start_r <= 1'b1;
            wait_r  <= 20'h0;
            state_r <= interlock_pkg::CTL_RUN;
          end
        end
        interlock_pkg::CTL_RUN: begin
          if (gone && fb) begin
            state_r <= interlock_pkg::CTL_FAIL;
          end else if (!RUN_REQ) begin
            stop_r  <= 1'b1;
            wait_r  <= 20'h0;
            state_r <= interlock_pkg::CTL_STOP;
          end
        end
        interlock_pkg::CTL_STOP: begin
          if (wait_r == 20'h2) begin
            en_r <= 1'b0;
          end
          if (gone) begin
            sf_r    <= 1'b0;
            state_r <= interlock_pkg::CTL_IDLE;
          end
        end
        interlock_pkg::CTL_FAIL: begin
          en_r <= 1'b0;
          sf_r <= 1'b0;
        end
        default: begin
          state_r <= interlock_pkg::CTL_IDLE;
        end
      endcase
    end
  end

  assign LINK.enable_in = en_r;
  assign LINK.safety_in = sf_r;
  assign LINK.start_cmd = start_r;
  assign LINK.stop_cmd  = stop_r;
  assign RUNNING        = state_r == interlock_pkg::CTL_RUN;
  assign FAILED         = state_r == interlock_pkg::CTL_FAIL;
endmodule

// ### test/interlock_checker.sv
// Assertions on the link between the lift sequencer and the interlock
`timescale 1ns/100ps
module interlock_checker (
  input wire logic CLK,
  input wire logic RST,
  input wire logic enable_in,
  input wire logic safety_in,
  input wire logic fbk_closed,
  input wire logic ready_closed,
  input wire logic start_cmd,
  input wire logic stop_cmd
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////////////////////
  // Margin of three cycles over sync, filter and output register
  chk_enable_low_off: assert property ((!enable_in)[*8] ##3 1'b1 |-> fbk_closed)
    else $error("feedback open with enable low");
  chk_safety_low_off: assert property ((!safety_in)[*8] ##3 1'b1 |-> fbk_closed)
    else $error("feedback open with safety low");
  chk_ready_open: assert property ((!enable_in)[*8] ##3 1'b1 |-> !ready_closed)
    else $error("ready relay closed with enable low");
  chk_start_opens: assert property (start_cmd |-> ##[1:4] !fbk_closed)
    else $error("feedback did not open after start");
  chk_open_by_start: assert property ($fell(fbk_closed) |->
    $past(start_cmd, 1) || $past(start_cmd, 2) || $past(start_cmd, 3))
    else $error("feedback opened without start");
  chk_stop_closes: assert property (stop_cmd |-> ##[1:4] fbk_closed)
    else $error("feedback not closed after stop");
  chk_safety_first: assert property ($rose(enable_in) |-> safety_in)
    else $error("enable raised before safety");
  chk_enable_drop_first: assert property ($fell(safety_in) |-> !enable_in)
    else $error("safety dropped before enable");
  chk_start_checked: assert property (start_cmd |->
    enable_in && safety_in && fbk_closed && ready_closed)
    else $error("start issued without feedback check");
  cov_start: cover property ($fell(fbk_closed));
  cov_stop: cover property (stop_cmd);
  cov_safety_drop: cover property ($fell(safety_in));
endmodule

// ### test/torque_off_enable_interlock_bench.sv
// Bench: sequencer against interlock, plus a bench-driven second interlock
`timescale 1ns/100ps
module torque_off_enable_interlock_bench;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       run_req = 1'b0;
  logic [1:0] clr = 2'h0;
  logic [1:0] sense = 2'h3;
  logic [1:0] fault = 2'h0;
  wire  [1:0] pen, toff, lck, mis, sal;
  logic       running, failed;
  int         miscompares = 0;
  int         tests_run = 0;
  interlock_if lk();
  interlock_if lk2();
  always #20 clk = ~clk;
  // Readback mirrors the contact unless a welded contact is injected
  always @(negedge clk) sense <= fault | {lk2.fbk_closed, lk.fbk_closed};
  lift_sequencer lift_sequencer_inst (.CLK(clk), .RST(rst), .LINK(lk.controller),
    .RUN_REQ(run_req), .RUNNING(running), .FAILED(failed));
  torque_off_enable_interlock torque_off_enable_interlock_inst (.CLK(clk), .RST(rst),
    .LINK(lk.device), .ALARM_CLEAR(clr[0]), .FBK_SENSE(sense[0]), .PULSE_EN(pen[0]),
    .TORQUE_OFF(toff[0]), .LOCKOUT(lck[0]), .MISSING_ALARM(mis[0]), .SAFETY_ALARM(sal[0]));
  // Second device faces the bench so the input order can be broken on purpose
  torque_off_enable_interlock torque_off_enable_interlock_inst2 (.CLK(clk), .RST(rst),
    .LINK(lk2.device), .ALARM_CLEAR(clr[1]), .FBK_SENSE(sense[1]), .PULSE_EN(pen[1]),
    .TORQUE_OFF(toff[1]), .LOCKOUT(lck[1]), .MISSING_ALARM(mis[1]), .SAFETY_ALARM(sal[1]));
  interlock_checker interlock_checker_inst (.CLK(clk), .RST(rst), .enable_in(lk.enable_in),
    .safety_in(lk.safety_in), .fbk_closed(lk.fbk_closed), .ready_closed(lk.ready_closed),
    .start_cmd(lk.start_cmd), .stop_cmd(lk.stop_cmd));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task test_done;
    if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task wait_run(input logic v);
    int i;
    for (i = 0; i < 30000 && running !== v; i++) @(negedge clk);
    chk(running, v);
  endtask
  task start2;
    lk2.start_cmd = 1'b1;
    cyc(1);
    lk2.start_cmd = 1'b0;
    cyc(4);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_run_stop;
    run_req = 1'b1;
    wait_run(1'b1);
    cyc(4);
    chk({pen[0], toff[0]}, 8'h2);
    chk({lk.fbk_closed, lk.ready_closed}, 8'h1);
    run_req = 1'b0;
    wait_run(1'b0);
    cyc(80);
    chk({lk.enable_in, lk.safety_in, pen[0], lk.fbk_closed, lk.ready_closed}, 8'h2);
  endtask
  task t_lockout;
    lk2.enable_in = 1'b1;
    cyc(20);
    lk2.safety_in = 1'b1;
    cyc(20);
    chk(lck[1], 1'b1);
    start2;
    chk(pen[1], 1'b0);
    lk2.enable_in = 1'b0;
    cyc(20);
    lk2.enable_in = 1'b1;
    cyc(20);
    chk({lck[1], lk2.ready_closed}, 8'h1);
    start2;
    chk({pen[1], toff[1], lk2.fbk_closed}, 8'h4);
    lk2.enable_in = 1'b0;
    cyc(1);
    lk2.enable_in = 1'b1;
    cyc(20);
    chk(pen[1], 1'b1);
    chk(mis, 8'h0);
    lk2.safety_in = 1'b0;
    cyc(20);
    chk({pen[1], toff[1], lk2.fbk_closed}, 8'h3);
    lk2.enable_in = 1'b0;
  endtask
  task t_fault;
    run_req = 1'b1;
    wait_run(1'b1);
    fault[0] = 1'b1;
    cyc(100);
    chk({sal[0], pen[0]}, 8'h2);
    chk(failed, 1'b1);
    fault[0] = 1'b0;
    run_req = 1'b0;
    cyc(40);
    chk(sal[0], 1'b1);
    clr[0] = 1'b1;
    cyc(1);
    clr[0] = 1'b0;
    cyc(2);
    chk(sal[0], 1'b0);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(2);
    chk({pen[0], lk.fbk_closed, lk.ready_closed}, 8'h2);
  endtask
  initial begin
    lk2.enable_in = 1'b0;
    lk2.safety_in = 1'b0;
    lk2.start_cmd = 1'b0;
    lk2.stop_cmd = 1'b0;
    cyc(20);
    rst = 1'b0;
    t_run_stop;
    t_lockout;
    t_fault;
    test_done;
  end
  // Two sequencer runs and the lockout test take well under a thousand cycles
  initial begin
    repeat (95000) @(posedge clk);
    miscompares++;
    test_done;
  end
endmodule
